// *** bench/touch_matrix_scan_sequencer_test.sv ***
// self-checking bench for the scan sequencer
// assumes the model and checker files compile first
`timescale 1ns/10ps
module test_touch_matrix_scan_sequencer;
    import touch_scan_pkg::*;
    localparam int CYC = 4000;
    logic clk, resetn, ce, slider_en, state_read, bz_q, scan_busy;
    logic bus_addr_sel_0, bus_addr_sel_1, sense_line0_b, sense_line1_b;
    logic gen_io_1_in, gen_io_2_in, gen_io_3_in, slider_touch;
    logic sense_line0_a, sense_line1_a, sample_out, change_n_out, change_n_oe;
    logic gen_io_1_out, gen_io_1_oe, gen_io_2_out, gen_io_2_oe, gen_io_3_out, gen_io_3_oe;
    logic [127:0] burst_len_setting;
    logic [11:0] touch_threshold, dly;
    logic [3:0] slider_len;
    logic [7:0] gpo_en, drive_lines, dl_q;
    logic [63:0] gpo_duty;
    logic [2:0] gpio_dir_out, gpio_in_state, slider_pos;
    logic [23:0] gpio_duty;
    logic [15:0] key_state;
    logic [191:0] signal_values;
    logic [4:0] scan_slots;
    logic [1:0] bus_addr;
    int err_total, check_count;
    int xs[$];
    touch_matrix_scan_sequencer #(.CYCLE_COUNT(CYC)) u_dut (.*);
    touch_sense_model u_model (.clk(clk), .resetn(resetn), .sample_out(sample_out),
        .delay(dly), .sense_line0_b(sense_line0_b), .sense_line1_b(sense_line1_b));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ********
    // pulse monitor and shared tasks
    // ********
    always @(negedge clk) begin
        if (scan_busy && bz_q && drive_lines != 8'h00 && dl_q == 8'h00) begin
            xs.push_back($clog2(drive_lines));
        end
        dl_q <= drive_lines;
        bz_q <= scan_busy;
    end
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wait_pass();
        int n;
        n = 0;
        while (scan_busy !== 1'b1 && n < 2 * CYC) begin
            @(negedge clk);
            n++;
        end
        while (scan_busy !== 1'b0 && n < 2 * CYC) begin
            @(negedge clk);
            n++;
        end
        check("pass done", n < 2 * CYC, 1);
    endtask
    // ********
    // scenarios
    // ********
    task automatic reset_case();
        @(negedge clk);
        check("reset drive", drive_lines, 0);
        check("reset clamp", {sense_line1_a, sense_line0_a}, 3);
        check("reset busy", {scan_busy, change_n_oe, sample_out}, 0);
    endtask
    task automatic scan_case(logic [127:0] cfg, int slots);
        int exp[$];
        wait_pass();
        @(posedge clk);
        burst_len_setting <= cfg;
        xs.delete();
        for (int k = 0; k < 16; k++) begin
            repeat (cfg[8*k+:8]) exp.push_back(k % 8);
        end
        wait_pass();
        check("pulse count", xs.size(), exp.size());
        foreach (exp[i]) check("pulse line", xs[i], exp[i]);
        check("slots", scan_slots, slots);
    endtask
    task automatic touch_case();
        logic [11:0] ref0;
        ref0 = signal_values[11:0];
        @(posedge clk);
        dly <= 12'h01e;
        slider_en <= 1'b1;
        slider_len <= 4'h2;
        wait_pass();
        check("keys touched", key_state, 16'hffff);
        check("signal drop", signal_values[11:0] < ref0, 1);
        @(posedge scan_busy);
        repeat (2) @(negedge clk);
        check("change pin", change_n_oe, 1);
        check("slider hit", slider_touch, 1);
        check("slider pos", slider_pos, 0);
        @(posedge clk);
        state_read <= 1'b1;
        @(posedge clk);
        state_read <= 1'b0;
        repeat (2) @(negedge clk);
        check("change clear", change_n_oe, 0);
    endtask
    task automatic pin_case();
        int hi;
        int hg;
        wait_pass();
        @(posedge clk);
        gpo_en <= 8'h01;
        gpo_duty <= {8{8'h80}};
        gpio_dir_out <= 3'h5;
        gen_io_2_in <= 1'b1;
        hi = 0;
        hg = 0;
        repeat (300) begin
            @(negedge clk);
            hi += drive_lines[0];
            hg += gen_io_1_out;
        end
        check("pwm toggles", hi > 0 && hi < 300, 1);
        check("pin pwm", hg > 0 && hg < 300, 1);
        check("input pin quiet", gen_io_2_out, 0);
        check("pin enables", {gen_io_3_oe, gen_io_2_oe, gen_io_1_oe}, 5);
        check("pin input", gpio_in_state, 2);
        check("bus addr", bus_addr, 1);
        @(posedge clk);
        gpo_en <= 8'h00;
        ce <= 1'b0;
        gen_io_2_in <= 1'b0;
        repeat (3) @(negedge clk);
        check("frozen input", gpio_in_state, 2);
        @(posedge clk);
        ce <= 1'b1;
        repeat (2) @(negedge clk);
        check("input follows", gpio_in_state, 0);
    endtask
    initial begin
        err_total = 0;
        check_count = 0;
        resetn = 1'b0;
        ce = 1'b1;
        burst_len_setting = '0;
        touch_threshold = 12'h010;
        dly = 12'h078;
        slider_en = 1'b0;
        slider_len = 4'h0;
        gpo_en = 8'h00;
        gpo_duty = '0;
        gpio_dir_out = 3'h0;
        gpio_duty = {3{8'h40}};
        state_read = 1'b0;
        bus_addr_sel_0 = 1'b1;
        bus_addr_sel_1 = 1'b0;
        gen_io_1_in = 1'b0;
        gen_io_2_in = 1'b0;
        gen_io_3_in = 1'b0;
        repeat (10) @(posedge clk);
        reset_case();
        @(posedge clk);
        resetn <= 1'b1;
        // keys 1, 10 and 15 only, three different burst lengths
        scan_case(128'h0300_0000_0001_0000_0000_0000_0000_0200, 3);
        scan_case({16{8'h01}}, 16);
        touch_case();
        pin_case();
        complete_run();
    end
    initial begin
        repeat (12 * CYC) @(posedge clk);
        err_total++;
        complete_run();
    end
endmodule
bind touch_matrix_scan_sequencer touch_scan_checker u_chk (
    .clk(clk), .resetn(resetn), .state_read(state_read), .slider_len(slider_len),
    .drive_lines(drive_lines), .sample_out(sample_out), .change_n_out(change_n_out),
    .change_n_oe(change_n_oe), .slider_touch(slider_touch), .slider_pos(slider_pos),
    .scan_slots(scan_slots), .scan_busy(scan_busy)
);

// *** bench/touch_scan_checker.sv ***
// port checks for the scan sequencer
// assumes a bind onto touch_matrix_scan_sequencer
`timescale 1ns/10ps
module touch_scan_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic state_read,
    input wire logic [3:0] slider_len,
    input wire logic [7:0] drive_lines,
    input wire logic sample_out,
    input wire logic change_n_out,
    input wire logic change_n_oe,
    input wire logic slider_touch,
    input wire logic [2:0] slider_pos,
    input wire logic [4:0] scan_slots,
    input wire logic scan_busy
);
    logic busy_ff;
    logic [5:0] hi_cnt_ff;
    logic [12:0] conv_cnt_ff;
    // ********
    // helper counters
    // ********
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_ff <= 1'b0;
            hi_cnt_ff <= 6'h00;
            conv_cnt_ff <= 13'h0000;
        end else begin
            busy_ff <= scan_busy;
            // first busy cycle still shows idle pwm, so it is skipped
            hi_cnt_ff <= (scan_busy && busy_ff && drive_lines != 8'h00) ?
                hi_cnt_ff + 6'h01 : 6'h00;
            conv_cnt_ff <= sample_out ? conv_cnt_ff + 13'h0001 : 13'h0000;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_conv;
        sample_out ##1 sample_out;
    endsequence
    sequence s_hi_end;
        scan_busy && busy_ff && hi_cnt_ff != 6'h00 && drive_lines == 8'h00;
    endsequence
    one_line_a: assert property (scan_busy && busy_ff |-> $onehot0(drive_lines))
        else $error("more than one drive line in scan");
    quiet_conv_a: assert property (s_conv |-> drive_lines == 8'h00)
        else $error("drive pulse during conversion");
    pulse_len_a: assert property (s_hi_end |-> hi_cnt_ff == 6'h20)
        else $error("drive pulse length wrong");
    conv_max_a: assert property (conv_cnt_ff <= 13'h1000)
        else $error("conversion too long");
    conv_start_a: assert property ($rose(sample_out) |->
        scan_busy && $past(drive_lines) == 8'h00)
        else $error("conversion before burst end");
    change_read_a: assert property ($fell(change_n_oe) |-> $past(state_read))
        else $error("change pin released without read");
    change_low_a: assert property (change_n_out == 1'b0)
        else $error("change pin drives high");
    slots_max_a: assert property (scan_slots <= 5'h10)
        else $error("too many timeslots");
    slider_pos_a: assert property (slider_touch |-> slider_pos < slider_len)
        else $error("slider position out of range");
endmodule

// *** bench/touch_sense_model.sv ***
// comparator model of the two sense channels
// assumes sample_out high for the whole conversion ramp
`timescale 1ns/10ps
module touch_sense_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sample_out,
    input wire logic [11:0] delay,
    output logic sense_line0_b,
    output logic sense_line1_b
);
    logic [11:0] ramp_ff;
    // ********
    // ramp and zero crossing
    // ********
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ramp_ff <= 12'h000;
        end else if (sample_out) begin
            ramp_ff <= ramp_ff + 12'h001;
        end else begin
            ramp_ff <= 12'h000;
        end
    end
    // drops as soon as the ramp stops, never holds a stale crossing
    assign sense_line0_b = sample_out && ramp_ff >= delay;
    // both channels cross together: y is not modelled apart
    assign sense_line1_b = sense_line0_b;
endmodule

// *** rtl/touch_matrix_scan_sequencer.sv ***
// touch matrix scan sequencer: key-by-key burst scan, slider, gpio/pwm, change pin
// assumes configuration arrives on plain ports from the host interface logic
`timescale 1ns/10ps
module touch_matrix_scan_sequencer #(
    parameter int CYCLE_COUNT = touch_scan_pkg::CYCLE_CLKS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [touch_scan_pkg::NUM_KEYS*touch_scan_pkg::BL_W-1:0] burst_len_setting,
    input wire logic [touch_scan_pkg::SIG_W-1:0] touch_threshold,
    input wire logic slider_en,
    input wire logic [3:0] slider_len,
    input wire logic [touch_scan_pkg::NUM_X-1:0] gpo_en,
    input wire logic [touch_scan_pkg::NUM_X*touch_scan_pkg::PWM_W-1:0] gpo_duty,
    input wire logic [touch_scan_pkg::NUM_GPIO-1:0] gpio_dir_out,
    input wire logic [touch_scan_pkg::NUM_GPIO*touch_scan_pkg::PWM_W-1:0] gpio_duty,
    input wire logic state_read,
    input wire logic bus_addr_sel_0,
    input wire logic bus_addr_sel_1,
    input wire logic sense_line0_b,
    input wire logic sense_line1_b,
    input wire logic gen_io_1_in,
    input wire logic gen_io_2_in,
    input wire logic gen_io_3_in,
    output logic [touch_scan_pkg::NUM_X-1:0] drive_lines,
    output logic sense_line0_a,
    output logic sense_line1_a,
    output logic sample_out,
    output logic gen_io_1_out,
    output logic gen_io_1_oe,
    output logic gen_io_2_out,
    output logic gen_io_2_oe,
    output logic gen_io_3_out,
    output logic gen_io_3_oe,
    output logic [touch_scan_pkg::NUM_GPIO-1:0] gpio_in_state,
    output logic change_n_out,
    output logic change_n_oe,
    output logic [touch_scan_pkg::NUM_KEYS-1:0] key_state,
    output logic [touch_scan_pkg::NUM_KEYS*touch_scan_pkg::SIG_W-1:0] signal_values,
    output logic slider_touch,
    output logic [2:0] slider_pos,
    output logic [4:0] scan_slots,
    output logic scan_busy,
    output logic [1:0] bus_addr
);
    import touch_scan_pkg::*;

    // ****************************************
    // state
    // ****************************************
    scan_e state_ff;
    logic [KEY_W-1:0] key_ff;
    logic [BL_W-1:0] pulse_cnt_ff;
    logic [5:0] dwell_ff;
    logic [SIG_W-1:0] ramp_ff;
    logic [31:0] cycle_ff;
    logic [4:0] slots_ff;
    logic [NUM_KEYS-1:0] key_state_ff;
    logic [NUM_KEYS-1:0] ref_valid_ff;
    logic [SIG_W-1:0] sig_ff [NUM_KEYS];
    logic [SIG_W-1:0] ref_ff [NUM_KEYS];
    logic [NUM_X-1:0] drive_ff;
    logic clamp0_ff;
    logic clamp1_ff;
    logic sample_ff;
    logic pass_change_ff;
    logic [PWM_W-1:0] pwm_cnt_ff;
    logic [NUM_X-1:0] gpo_lvl;
    logic [NUM_GPIO-1:0] gpio_lvl;
    logic [NUM_GPIO-1:0] gpio_out_ff;
    logic [NUM_GPIO-1:0] gpio_oe_ff;
    logic [NUM_GPIO-1:0] gpio_in_ff;
    logic change_pend_ff;
    logic slider_touch_ff;
    logic [2:0] slider_pos_ff;
    logic [1:0] addr_ff;
    logic addr_taken_ff;

    logic [BL_W-1:0] cur_bl;
    logic cur_y;
    logic [2:0] cur_x;
    logic cmp_hit;
    logic cycle_tick;
    logic dwell_done;
    logic busy_ff;
    logic [SIG_W:0] sig_sum;
    logic touch_now;

    // key index = x + 8*y, so low bits pick x, top bit picks y
    assign cur_x = key_ff[2:0];
    assign cur_y = key_ff[KEY_W-1];
    assign cur_bl = burst_len_setting[key_ff*BL_W +: BL_W]; // per-key length
    assign cmp_hit = cur_y ? sense_line1_b : sense_line0_b;
    // one bit wider so a saturated ramp plus threshold never wraps into a touch
    assign sig_sum = {1'b0, ramp_ff} + {1'b0, touch_threshold};
    assign touch_now = (sig_sum < {1'b0, ref_ff[key_ff]});
    assign cycle_tick = (cycle_ff == 32'(CYCLE_COUNT - 1));
    assign dwell_done = (dwell_ff == 6'(DWELL_CLKS - 1));

    // ****************************************
    // 16 ms cycle timer
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cycle_ff <= 32'h0;
        end else if (ce) begin
            cycle_ff <= cycle_tick ? 32'h0 : cycle_ff + 32'h1;
        end
    end

    // ****************************************
    // scan sequencer
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= SLEEP;
            key_ff <= FIRST_KEY;
            pulse_cnt_ff <= BL_OFF;
            dwell_ff <= 6'h0;
            ramp_ff <= SIG_ZERO;
            slots_ff <= 5'h0;
            busy_ff <= 1'b0;
        end else if (ce) begin
            unique case (state_ff)
                SLEEP: begin
                    if (cycle_tick) begin // sleep until the next cycle
                        key_ff <= FIRST_KEY;
                        slots_ff <= 5'h0;
                        busy_ff <= 1'b1;
                        state_ff <= SELECT;
                    end
                end
                SELECT: begin
                    // one key per step; disabled keys skip straight on
                    pulse_cnt_ff <= BL_OFF;
                    dwell_ff <= 6'h0;
                    if (cur_bl != BL_OFF) begin
                        slots_ff <= slots_ff + 5'h1;
                        state_ff <= PULSE_HI;
                    end else if (key_ff == LAST_KEY) begin
                        busy_ff <= 1'b0;
                        state_ff <= SLEEP;
                    end else begin
                        key_ff <= key_ff + 4'h1;
                    end
                end
                PULSE_HI: begin
                    dwell_ff <= dwell_done ? 6'h0 : dwell_ff + 6'h1;
                    if (dwell_done) begin
                        state_ff <= PULSE_LO;
                    end
                end
                PULSE_LO: begin
                    dwell_ff <= dwell_done ? 6'h0 : dwell_ff + 6'h1;
                    if (dwell_done) begin
                        pulse_cnt_ff <= pulse_cnt_ff + 8'h1;
                        ramp_ff <= SIG_ZERO;
                        // whole burst before conversion
                        state_ff <= (pulse_cnt_ff + 8'h1 == cur_bl) ? CONVERT : PULSE_HI;
                    end
                end
                CONVERT: begin
                    // ramp time to zero crossing is the result
                    if (cmp_hit || ramp_ff == SIG_MAX) begin
                        state_ff <= PROCESS;
                    end else begin
                        ramp_ff <= ramp_ff + 12'h1;
                    end
                end
                PROCESS: begin
                    if (key_ff == LAST_KEY) begin
                        busy_ff <= 1'b0;
                        state_ff <= SLEEP;
                    end else begin
                        key_ff <= key_ff + 4'h1; // next key only after this one
                        state_ff <= SELECT;
                    end
                end
                default: begin
                    // unused state codes fall back to sleep
                    busy_ff <= 1'b0;
                    state_ff <= SLEEP;
                end
            endcase
        end
    end

    // ****************************************
    // result store and touch decision
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            key_state_ff <= '0;
            ref_valid_ff <= '0;
            pass_change_ff <= 1'b0;
            for (int i = 0; i < NUM_KEYS; i++) begin
                sig_ff[i] <= SIG_ZERO;
                ref_ff[i] <= SIG_ZERO;
            end
        end else if (ce) begin
            if (state_ff == PROCESS) begin
                sig_ff[key_ff] <= ramp_ff;
                if (!ref_valid_ff[key_ff]) begin
                    // first result after reset calibrates the key
                    ref_ff[key_ff] <= ramp_ff;
                    ref_valid_ff[key_ff] <= 1'b1;
                end else begin
                    key_state_ff[key_ff] <= touch_now;
                    if (touch_now != key_state_ff[key_ff]) begin
                        pass_change_ff <= 1'b1;
                    end
                end
            end else if (state_ff == SELECT && cur_bl == BL_OFF) begin
                key_state_ff[key_ff] <= 1'b0; // disabled key never reads touched
                ref_valid_ff[key_ff] <= 1'b0;
                if (key_state_ff[key_ff]) begin
                    pass_change_ff <= 1'b1;
                end
            end else if (state_ff == SLEEP && cycle_tick) begin
                // kept through sleep so the change pin sees it at the tick
                pass_change_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // matrix pins and sample output
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drive_ff <= '0;
            clamp0_ff <= 1'b1;
            clamp1_ff <= 1'b1;
            sample_ff <= 1'b0;
        end else if (ce) begin
            for (int i = 0; i < NUM_X; i++) begin
                // only the active x pulses; other lines stay low, and all lines serve as pwm outputs in SLEEP and SELECT
                if (state_ff == PULSE_HI && cur_x == 3'(i)) begin
                    drive_ff[i] <= 1'b1;
                end else if (state_ff == SLEEP || state_ff == SELECT) begin
                    drive_ff[i] <= gpo_en[i] & gpo_lvl[i];
                end else begin
                    drive_ff[i] <= 1'b0;
                end
            end
            // y clamped on falling x edge and after the burst; free while charging
            clamp0_ff <= !(state_ff == PULSE_HI && !cur_y);
            clamp1_ff <= !(state_ff == PULSE_HI && cur_y);
            sample_ff <= (state_ff == CONVERT);
        end
    end

    // ****************************************
    // pwm for x lines and general pins
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pwm_cnt_ff <= '0;
        end else if (ce) begin
            pwm_cnt_ff <= pwm_cnt_ff + 8'h1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_X; g++) begin : gen_gpo_pwm
            assign gpo_lvl[g] = pwm_cnt_ff < gpo_duty[g*PWM_W +: PWM_W];
        end
        for (g = 0; g < NUM_GPIO; g++) begin : gen_gpio_pwm
            assign gpio_lvl[g] = pwm_cnt_ff < gpio_duty[g*PWM_W +: PWM_W];
        end
    endgenerate

    // ****************************************
    // general purpose pins
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gpio_out_ff <= '0;
            gpio_oe_ff <= '0;
            gpio_in_ff <= '0;
        end else if (ce) begin
            gpio_oe_ff <= gpio_dir_out; // input or driven output per pin
            gpio_out_ff <= gpio_lvl & gpio_dir_out;
            gpio_in_ff <= {gen_io_3_in, gen_io_2_in, gen_io_1_in} & ~gpio_dir_out;
        end
    end

    // ****************************************
    // slider on y0 starting at x0
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            slider_touch_ff <= 1'b0;
            slider_pos_ff <= 3'h0;
        end else if (ce && state_ff == SLEEP && cycle_tick) begin
            slider_touch_ff <= 1'b0;
            slider_pos_ff <= 3'h0;
            // lengths outside 2..8 leave the slider off
            if (slider_en && slider_len >= SLIDER_MIN && slider_len <= SLIDER_MAX) begin
                for (int i = NUM_X - 1; i >= 0; i--) begin
                    if (4'(i) < slider_len && key_state_ff[i]) begin // keys 0..len-1
                        slider_touch_ff <= 1'b1;
                        slider_pos_ff <= 3'(i);
                    end
                end
            end
        end
    end

    // ****************************************
    // change notification
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            change_pend_ff <= 1'b0;
        end else if (ce) begin
            // set wins over a read in the same cycle
            // inputs compared only once sampled: a high idle pin is no false change
            if ((state_ff == SLEEP && cycle_tick && pass_change_ff) ||
                (addr_taken_ff &&
                 gpio_in_ff != ({gen_io_3_in, gen_io_2_in, gen_io_1_in} & ~gpio_dir_out))) begin
                change_pend_ff <= 1'b1;
            end else if (state_read) begin
                change_pend_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // address strap, caught after reset release
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_ff <= 2'h0;
            addr_taken_ff <= 1'b0;
        end else if (ce && !addr_taken_ff) begin
            addr_ff <= {bus_addr_sel_1, bus_addr_sel_0}; // slave address for the host
            addr_taken_ff <= 1'b1;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_comb begin
        for (int i = 0; i < NUM_KEYS; i++) begin
            signal_values[i*SIG_W +: SIG_W] = sig_ff[i];
        end
    end
    assign drive_lines = drive_ff;
    assign sense_line0_a = clamp0_ff;
    assign sense_line1_a = clamp1_ff;
    assign sample_out = sample_ff;
    assign gen_io_1_out = gpio_out_ff[0];
    assign gen_io_2_out = gpio_out_ff[1];
    assign gen_io_3_out = gpio_out_ff[2];
    assign gen_io_1_oe = gpio_oe_ff[0];
    assign gen_io_2_oe = gpio_oe_ff[1];
    assign gen_io_3_oe = gpio_oe_ff[2];
    assign gpio_in_state = gpio_in_ff;
    // open drain: only ever pulls low
    assign change_n_out = 1'b0;
    assign change_n_oe = change_pend_ff;
    assign key_state = key_state_ff;
    assign slider_touch = slider_touch_ff;
    assign slider_pos = slider_pos_ff;
    assign scan_slots = slots_ff;
    assign scan_busy = busy_ff;
    assign bus_addr = addr_ff;
endmodule

// *** rtl/touch_scan_pkg.sv ***
// constants for the touch matrix scan sequencer
// assumes a 125 MHz core clock
package touch_scan_pkg;
    // ****************************************
    // matrix geometry
    // ****************************************
    localparam int NUM_X = 8;
    localparam int NUM_Y = 2;
    localparam int NUM_KEYS = NUM_X * NUM_Y;
    localparam int KEY_W = 4;
    localparam int BL_W = 8;
    localparam int SIG_W = 12;
    localparam int NUM_GPIO = 3;
    localparam int PWM_W = 8;
    localparam logic [KEY_W-1:0] FIRST_KEY = 4'h0;
    localparam logic [KEY_W-1:0] LAST_KEY = 4'hf;
    localparam logic [BL_W-1:0] BL_OFF = 8'h00;
    // ****************************************
    // slider limits
    // ****************************************
    localparam logic [3:0] SLIDER_MIN = 4'h2;
    localparam logic [3:0] SLIDER_MAX = 4'h8;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 125;
    localparam int CLK_PERIOD_NS = 8;
    localparam int CYCLE_MS = 16;
    localparam int CYCLE_CLKS = CYCLE_MS * 1000 * CLK_MHZ;
    localparam int DWELL_NS = 250;
    localparam int DWELL_CLKS = (DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [SIG_W-1:0] SIG_MAX = 12'hfff;
    localparam logic [SIG_W-1:0] SIG_ZERO = 12'h000;
    // ****************************************
    // scan states
    // ****************************************
    typedef enum logic [2:0] {
        SLEEP, SELECT, PULSE_HI, PULSE_LO, CONVERT, PROCESS
    } scan_e;
endpackage
